// [core/gfm_regs.vh]
// register map, field layout and timing constants for the gpio function mapper
// Summary of operation
// R01: low seven bits of each line map register index a table bit.
// R02: control table and status table each hold 128 bits.
// R03: bit 7 selects direction: 0 control input, 1 status output.
// R04: line 2 map register resets to 0x60, fast diff output zero enable.
// R05: line 1, 3, 4, 5, 6 map registers reset to zero, unused.
// R06: writing spur reduction setting starts a reconfiguration lasting up to 200 ms; code starts one only when the written value differs.
// R07: host makes no reads or writes during the reconfiguration period.
// R08: host writes spur setting only with 24.576 MHz master clock, tool values; code times reconfiguration from a 10 MHz clock.
// R09: line 0 map register has same layout and resets to zero.
// R10: control mode copies pin into control bit; status mode drives status bit.
`ifndef GFM_REGS_VH
`define GFM_REGS_VH
`define GFM_ADDR_LINE0 8'he0
`define GFM_ADDR_LINE1 8'he1
`define GFM_ADDR_LINE2 8'he2
`define GFM_ADDR_LINE3 8'he3
`define GFM_ADDR_LINE4 8'he4
`define GFM_ADDR_LINE5 8'he5
`define GFM_ADDR_LINE6 8'he6
`define GFM_ADDR_SPUR 8'hf7
`define GFM_ADDR_BUSY 8'hf8
`define GFM_RST_LINE0 8'h00
`define GFM_RST_LINE1 8'h00
`define GFM_RST_LINE2 8'h60
`define GFM_RST_LINE_UNUSED 8'h00
`define GFM_RST_SPUR 8'h00
`define GFM_IDX_MSB 6
`define GFM_DIR_BIT 7
`define GFM_DIR_STATUS 1'b1
`define GFM_RECONF_MS 200
`define GFM_CLK_HZ 10000000
`define GFM_MS_PER_S 1000
`endif

// [core/gfm_line.v]
// one general purpose line: map register decode, control capture, status drive
`timescale 1ns/1ps
`include "gfm_regs.vh"
module gfm_line #(
  parameter [7:0] RST_MAP = 8'h00,
  parameter [7:0] ADDR = 8'he0,
  parameter TBL = 128
) (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire i_wr,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_pin,
  input wire [TBL-1:0] i_status_tbl,
  output reg [7:0] o_map,
  output reg o_pin_out,
  output reg o_pin_oe,
  output wire o_ctl_we,
  output wire [6:0] o_ctl_idx,
  output wire o_ctl_val
);
  wire [6:0] line_table_index;
  wire line_direction_select;
  assign line_table_index = o_map[`GFM_IDX_MSB:0];
  assign line_direction_select = o_map[`GFM_DIR_BIT];
  // R04 R05 R09 map reset values
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_map <= RST_MAP;
    end else if (i_wr && i_addr == ADDR) begin
      o_map <= i_wdata;
    end
  end
  // R03 R10 status drive
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pin_out <= 1'b0;
      o_pin_oe <= 1'b0;
    end else begin
      o_pin_oe <= (line_direction_select == `GFM_DIR_STATUS);
      // R01 index into status table
      o_pin_out <= (line_direction_select == `GFM_DIR_STATUS) ?
                   i_status_tbl[line_table_index] : 1'b0;
    end
  end
  // R10 control capture request
  assign o_ctl_we = (line_direction_select != `GFM_DIR_STATUS);
  assign o_ctl_idx = line_table_index;
  assign o_ctl_val = i_pin;
endmodule // gfm_line

// [core/gfm_top.v]
// gpio function mapper: line map registers, control/status tables, spur reconfig
`timescale 1ns/1ps
`include "gfm_regs.vh"
module gfm_top #(
  parameter LINES = 7,
  parameter TBL = 128,
  parameter RECONF_CYCLES = (`GFM_CLK_HZ / `GFM_MS_PER_S) * `GFM_RECONF_MS
) (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [TBL-1:0] i_status_tbl,
  input wire [LINES-1:0] i_pin,
  output reg [7:0] o_rdata,
  output reg [LINES-1:0] o_pin_out,
  output reg [LINES-1:0] o_pin_oe,
  output reg [TBL-1:0] o_ctl_tbl,
  output reg [7:0] o_spur_setting,
  output reg o_reconf_busy
);
  localparam [7:0] BASE = `GFM_ADDR_LINE0;

  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_RECONF = 3'h2;
  localparam [2:0] ST_DONE = 3'h4;

  localparam [7:0] M0 = `GFM_RST_LINE0;
  localparam [7:0] M1 = `GFM_RST_LINE1;
  localparam [7:0] M2 = `GFM_RST_LINE2;
  localparam [7:0] MU = `GFM_RST_LINE_UNUSED;
  localparam CNT_W = 32;
  localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
  localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam [CNT_W-1:0] RECONF_LAST = RECONF_CYCLES - 1;

  // per-line views, flattened
  wire [8*LINES-1:0] map_flat;
  wire [LINES-1:0] pin_out_w;
  wire [LINES-1:0] pin_oe_w;
  wire [LINES-1:0] ctl_we;
  wire [7*LINES-1:0] ctl_idx;
  wire [LINES-1:0] ctl_val;
  // host writes are dropped while reconfiguring
  wire wr_ok;
  assign wr_ok = i_wr && !o_reconf_busy;
  // host reads are refused while reconfiguring
  wire rd_ok;
  assign rd_ok = i_rd && !o_reconf_busy;

  // R04 R05 R09 reset value of each line map register
  function [7:0] line_reset;
    input integer num;
    begin
      case (num)
        0: line_reset = M0;
        1: line_reset = M1;
        2: line_reset = M2;
        default: line_reset = MU;
      endcase
    end
  endfunction

  // one map register and pin stage per line
  genvar g;
  generate
    for (g = 0; g < LINES; g = g + 1) begin : g_line
      localparam integer LINE_NUM = g;
      localparam [7:0] LINE_ADDR = BASE + LINE_NUM[7:0];
      // R04 R05 R09 per-line reset value
      localparam [7:0] LINE_RST = line_reset(LINE_NUM);
      gfm_line #(
        .RST_MAP(LINE_RST),
        .ADDR(LINE_ADDR),
        .TBL(TBL)
      ) u_line (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_wr(wr_ok),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_pin(i_pin[g]),
        .i_status_tbl(i_status_tbl),
        .o_map(map_flat[8*g+7:8*g]),
        .o_pin_out(pin_out_w[g]),
        .o_pin_oe(pin_oe_w[g]),
        .o_ctl_we(ctl_we[g]),
        .o_ctl_idx(ctl_idx[7*g+6:7*g]),
        .o_ctl_val(ctl_val[g])
      );
    end
  endgenerate

  // registered pin drive toward the board
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pin_out <= {LINES{1'b0}};
      o_pin_oe <= {LINES{1'b0}};
    end else begin
      o_pin_out <= pin_out_w;
      o_pin_oe <= pin_oe_w;
    end
  end

  // R02 control table, higher line wins on shared index
  reg [TBL-1:0] ctl_d;
  integer k;
  always @* begin
    ctl_d = o_ctl_tbl;
    for (k = 0; k < LINES; k = k + 1) begin
      if (ctl_we[k]) begin
        // R10 copy pin level
        ctl_d[ctl_idx[7*k +: 7]] = ctl_val[k];
      end
    end
  end

  // R04 line 2 default drives control bit 0x60 from pin at reset level
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ctl_tbl <= {TBL{1'b0}};
    end else begin
      o_ctl_tbl <= ctl_d;
    end
  end

  // R06 reconfiguration timer
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [CNT_W-1:0] cnt_q;
  reg [CNT_W-1:0] cnt_d;
  reg [7:0] spur_d;
  reg busy_d;
  wire spur_wr;
  wire spur_change;
  wire reconf_done;
  assign spur_wr = wr_ok && (i_addr == `GFM_ADDR_SPUR);
  assign spur_change = (i_wdata != o_spur_setting);
  assign reconf_done = (cnt_q == CNT_ZERO);

  // next state, count and setting
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    spur_d = o_spur_setting;
    busy_d = o_reconf_busy;
    case (state_q)
      ST_IDLE: begin
        if (spur_wr) begin
          spur_d = i_wdata;
          // R06 start only on a changed value
          if (spur_change) begin
            state_d = ST_RECONF;
            cnt_d = RECONF_LAST;
            busy_d = 1'b1;
          end
        end
      end
      ST_RECONF: begin
        if (reconf_done) begin
          state_d = ST_DONE;
        end else begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      ST_DONE: begin
        busy_d = 1'b0;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
        busy_d = 1'b0;
      end
    endcase
  end

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= CNT_ZERO;
      o_spur_setting <= `GFM_RST_SPUR;
      o_reconf_busy <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      o_spur_setting <= spur_d;
      o_reconf_busy <= busy_d;
    end
  end

  // R07 reads during reconfiguration return zero
  reg [7:0] rd_d;
  reg [7:0] line_rd;
  integer j;
  always @* begin
    line_rd = 8'h00;
    for (j = 0; j < LINES; j = j + 1) begin
      if (i_addr == BASE + j[7:0]) begin
        line_rd = map_flat[8*j +: 8];
      end
    end
    case (i_addr)
      `GFM_ADDR_SPUR: begin
        rd_d = o_spur_setting;
      end
      `GFM_ADDR_BUSY: begin
        rd_d = {7'h00, o_reconf_busy};
      end
      default: begin
        rd_d = line_rd;
      end
    endcase
  end

  // read data stands one cycle, then zero
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (rd_ok) begin
      o_rdata <= rd_d;
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule // gfm_top

// [test/gfm_top_monitor.sv]
// port-level assertions for the gpio function mapper
`timescale 1ns/1ps
module gfm_top_monitor #(
  parameter RECONF_CYCLES = 20
) (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire [6:0] o_pin_oe,
  input wire [7:0] o_spur_setting,
  input wire o_reconf_busy
);
  reg [31:0] bc_q;
  wire spur_wr = i_wr && i_addr == 8'hf7 && !o_reconf_busy;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // busy cycle count
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) bc_q <= 32'h0;
    else bc_q <= o_reconf_busy ? bc_q + 32'h1 : 32'h0;
  end
  chk_spur_echo: assert property (spur_wr |=> o_spur_setting == $past(i_wdata))
    else $error("spur not taken");
  chk_busy_start: assert property (spur_wr && i_wdata != o_spur_setting |=> o_reconf_busy)
    else $error("no busy");
  chk_same_spur: assert property (spur_wr && i_wdata == o_spur_setting |=> !o_reconf_busy)
    else $error("busy on rewrite");
  chk_busy_len: assert property ($fell(o_reconf_busy) |-> bc_q == RECONF_CYCLES + 1)
    else $error("busy length");
  chk_oe_follow: assert property (
    i_wr && !o_reconf_busy && i_addr == 8'he3 |-> ##3 o_pin_oe[3] == $past(i_wdata[7], 3))
    else $error("oe not following map");
  chk_spur_read: assert property (
    i_rd && i_addr == 8'hf7 && !o_reconf_busy |=> o_rdata == o_spur_setting)
    else $error("spur read");
  chk_unmapped_zero: assert property (i_rd && i_addr == 8'he7 |=> o_rdata == 8'h00)
    else $error("unmapped read");
  chk_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("rdata not idle");
endmodule // gfm_top_monitor
bind gfm_top gfm_top_monitor #(.RECONF_CYCLES(RECONF_CYCLES)) u_mon (.*);

// [test/gfm_board.sv]
// board side model: resolves each line from device drive or board level
`timescale 1ns/1ps
module gfm_board (
  input wire [6:0] i_out,
  input wire [6:0] i_oe,
  input wire [6:0] i_lvl,
  output wire [6:0] o_pin
);
  assign o_pin = (i_oe & i_out) | (~i_oe & i_lvl);
endmodule // gfm_board

// [test/gfm_top_bench.sv]
// self-checking bench for the gpio function mapper
`timescale 1ns/1ps
module gfm_top_bench;
  localparam RC = 20;
  logic i_ref_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, o_reconf_busy;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, o_spur_setting;
  logic [127:0] i_status_tbl = 128'h0, o_ctl_tbl;
  logic [6:0] i_pin, lvl = 7'h00, o_pin_out, o_pin_oe;
  int bad_count = 0, checks_done = 0, cyc = 0, n;
  logic [31:0] rows [9] = '{32'he0001111, 32'he1002222, 32'he2603333, 32'he3004444,
    32'he4005555, 32'he5006666, 32'he6007777, 32'he7009900, 32'hf8009900};
  always #50 i_ref_clk = ~i_ref_clk;
  gfm_top #(.RECONF_CYCLES(RC)) uut (.*);
  gfm_board board (.i_out(o_pin_out), .i_oe(o_pin_oe), .i_lvl(lvl), .o_pin(i_pin));
  task automatic ck(input string nm, input logic [127:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 ck("rdata", o_rdata, exp);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 1000) begin
      bad_count++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (2) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    foreach (rows[k]) begin
      rd(rows[k][31:24], rows[k][23:16]);
      wr(rows[k][31:24], rows[k][15:8]);
      rd(rows[k][31:24], rows[k][7:0]);
    end
    @(posedge i_ref_clk) i_status_tbl <= 128'h20;
    wr(8'he3, 8'h85);
    repeat (2) @(posedge i_ref_clk);
    #1 ck("oe3", o_pin_oe[3], 1'b1);
    ck("out3", i_pin[3], 1'b1);
    @(posedge i_ref_clk) i_status_tbl <= 128'h0;
    repeat (3) @(posedge i_ref_clk);
    #1 ck("out3", o_pin_out[3], 1'b0);
    wr(8'he4, 8'h7f);
    lvl[4] <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    #1 ck("ctl", o_ctl_tbl[127], 1'b1);
    @(posedge i_ref_clk) lvl[4] <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    #1 ck("ctl", o_ctl_tbl[127], 1'b0);
    wr(8'hf7, 8'h3c);
    #1 ck("busy", o_reconf_busy, 1'b1);
    ck("spur", o_spur_setting, 8'h3c);
    n = 0;
    while (o_reconf_busy && n < 100) begin
      @(posedge i_ref_clk);
      #1 n++;
    end
    ck("busylen", n, RC + 1);
    rd(8'hf7, 8'h3c);
    wr(8'hf7, 8'h3c);
    #1 ck("rebusy", o_reconf_busy, 1'b0);
    @(posedge i_ref_clk) i_rst_n <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    rd(8'he2, 8'h60);
    @(posedge i_ref_clk) lvl[2] <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    #1 ck("ctl96", o_ctl_tbl[96], 1'b1);
    rd(8'hf7, 8'h00);
    tally_and_finish;
  end
endmodule // gfm_top_bench
